// >>> hdl/host_port_pkg.sv
// shared constants and types of the byte-wide host port
// assumes the host pins are already synchronous to the core clock
package host_port_pkg;
  localparam logic [2:0] BOOT_PATTERN = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_ZERO = 3'h4;
  localparam logic [2:0] ADDR_HIGH = 3'h5;
  localparam logic [2:0] ADDR_LOW = 3'h7;
  localparam logic [1:0] IDX_HIGH = 2'h0;
  localparam logic [1:0] IDX_MID = 2'h1;
  localparam logic [1:0] IDX_LOW = 2'h2;
  localparam logic [1:0] WS_OFF = 2'h0;
  localparam logic [1:0] WS_24 = 2'h1;
  localparam logic [1:0] WS_16 = 2'h2;
  localparam int BOOT_WORDS = 4608;
  localparam logic [12:0] EXEC_START = 13'h0000;
  localparam logic [7:0] VEC_RX = 8'h20;
  localparam logic [7:0] VEC_TX = 8'h22;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [23:0] WORD_RESET = 24'h000000;
  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_REQ = 2'b01,
    DMA_ACK = 2'b10
  } dma_state_t;
endpackage

// >>> hdl/word_stream_if.sv
// valid/ready word carrier between the port modules
// assumes both ends run on the same clock
`default_nettype none
interface word_stream_if #(parameter int W = 24);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> hdl/word_buffer.sv
// two-entry word buffer, flip-flop storage
// assumes one clock and the asynchronous active-low reset
`default_nettype none
module word_buffer #(
  parameter int W = 24
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  word_stream_if.snk in_s,
  word_stream_if.src out_s
);
  logic [W-1:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_s.ready = (count_reg != 2'h2);
  assign out_s.valid = (count_reg != 2'h0);
  assign out_s.data = mem_reg[rd_ptr_reg];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/host_port.sv
// host port: host byte registers, core word registers, dma pacing, boot load
// assumes host pins synchronous to i_ref_clk; control bits arrive as plain ports
`default_nettype none
module host_port #(
  parameter int BOOT_WORDS = host_port_pkg::BOOT_WORDS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_boot_active,
  input wire logic i_boot_mode_bit_c,
  input wire logic i_boot_mode_bit_b,
  input wire logic i_boot_mode_bit_a,
  input wire logic i_host_enable_n,
  input wire logic i_host_rw,
  input wire logic [2:0] i_host_reg_select,
  input wire logic [7:0] i_host_data_bus,
  output logic [7:0] o_host_data_bus,
  output logic o_host_data_oe,
  input wire logic i_host_ack_n,
  output logic o_host_request_n,
  input wire logic i_init,
  input wire logic i_host_flag_zero,
  input wire logic i_rx_request_enable,
  input wire logic i_tx_request_enable,
  input wire logic i_word_size_bit1,
  input wire logic i_word_size_bit0,
  input wire logic i_core_tx_wr,
  input wire logic [23:0] i_core_tx_data,
  input wire logic i_core_rx_rd,
  output logic [23:0] o_core_rx_data,
  output logic o_core_rx_full,
  output logic o_core_tx_empty,
  input wire logic i_core_tx_irq_enable,
  input wire logic i_core_rx_irq_enable,
  input wire logic i_irq_unmasked,
  output logic o_core_irq,
  output logic [7:0] o_core_irq_vector,
  output logic o_boot_from_host,
  output logic o_boot_wr,
  output logic [12:0] o_boot_addr,
  output logic [23:0] o_boot_data,
  output logic o_boot_done,
  output logic [12:0] o_exec_addr
);
  localparam logic [12:0] BOOT_LAST = 13'(BOOT_WORDS - 1);

  // start byte of a dma word from the size bits
  function automatic logic [1:0] start_index(input logic [1:0] ws);
    unique case (ws)
      host_port_pkg::WS_24: start_index = host_port_pkg::IDX_HIGH;
      host_port_pkg::WS_16: start_index = host_port_pkg::IDX_MID;
      default: start_index = host_port_pkg::IDX_LOW;
    endcase
  endfunction

  word_stream_if #(.W(24)) tx_s ();
  word_stream_if #(.W(24)) rx_s ();

  word_buffer #(.W(24)) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .in_s(tx_s),
    .out_s(rx_s)
  );

  logic en_n_reg;
  logic ack_n_reg;
  logic [7:0] tx_byte_reg [3];
  logic [7:0] rx_byte_reg [3];
  logic word_full_reg;
  logic host_rx_full_reg;
  logic core_tx_empty_reg;
  logic [23:0] core_tx_reg;
  logic core_rx_full_reg;
  logic [23:0] core_rx_reg;
  logic [1:0] cnt_reg;
  host_port_pkg::dma_state_t state_reg;
  host_port_pkg::dma_state_t state_next;
  logic [7:0] rd_data_next;
  logic [7:0] rd_data_reg;
  logic [7:0] vector_reg;
  logic boot_host_reg;
  logic boot_done_reg;
  logic boot_wr_reg;
  logic [12:0] boot_addr_reg;
  logic [23:0] boot_data_reg;

  logic [1:0] ws;
  logic [1:0] sel_idx;
  logic sel_byte;
  logic acc;
  logic host_wr;
  logic host_rd;
  logic ack_fall;
  logic ack_rise;
  logic dma_on;
  logic dma_tx;
  logic dma_rx;
  logic host_tx_empty;
  logic host_low_wr;
  logic dma_step;
  logic dma_low;
  logic copy_out;
  logic host_low_rd;
  logic boot_busy;
  logic boot_store;
  logic tx_irq;
  logic rx_irq;

  assign ws = {i_word_size_bit1, i_word_size_bit0};
  assign sel_idx = 2'(i_host_reg_select - host_port_pkg::ADDR_HIGH);
  assign sel_byte = (i_host_reg_select >= host_port_pkg::ADDR_HIGH);
  // one access per enable low phase, one step per ack release
  assign acc = ~i_host_enable_n & en_n_reg;
  assign host_wr = acc & ~i_host_rw;
  assign host_rd = acc & i_host_rw;
  assign ack_fall = ~i_host_ack_n & ack_n_reg;
  assign ack_rise = i_host_ack_n & ~ack_n_reg;
  assign dma_on = (ws != host_port_pkg::WS_OFF) & (i_tx_request_enable ^ i_rx_request_enable);
  assign dma_tx = dma_on & i_tx_request_enable;
  assign dma_rx = dma_on & i_rx_request_enable;
  assign host_tx_empty = ~word_full_reg;
  assign host_low_wr = host_wr & (i_host_reg_select == host_port_pkg::ADDR_LOW) & ~dma_tx;
  assign dma_step = (state_reg == host_port_pkg::DMA_ACK) & ack_rise;
  assign dma_low = dma_step & (cnt_reg == host_port_pkg::IDX_LOW);
  assign copy_out = ~host_rx_full_reg & ~core_tx_empty_reg;
  assign host_low_rd = host_rd & (i_host_reg_select == host_port_pkg::ADDR_LOW) & ~dma_rx;
  assign boot_busy = boot_host_reg & i_boot_active & ~boot_done_reg;
  assign boot_store = boot_busy & ~i_host_flag_zero & core_rx_full_reg;

  assign tx_s.valid = word_full_reg;
  assign tx_s.data = {tx_byte_reg[0], tx_byte_reg[1], tx_byte_reg[2]};
  assign rx_s.ready = ~core_rx_full_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_n_reg <= 1'b1;
      ack_n_reg <= 1'b1;
    end else begin
      en_n_reg <= i_host_enable_n;
      ack_n_reg <= i_host_ack_n;
    end
  end

  // host-to-core byte assembly
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 3; i++) begin
        tx_byte_reg[i] <= 8'h00;
      end
    end else if (dma_tx && dma_step) begin
      tx_byte_reg[cnt_reg] <= i_host_data_bus;
    end else if (host_wr && sel_byte && !dma_tx) begin
      tx_byte_reg[sel_idx] <= i_host_data_bus;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_full_reg <= 1'b0;
    end else if (host_low_wr || (dma_tx && dma_low)) begin
      word_full_reg <= 1'b1;
    end else if (i_init || (tx_s.valid && tx_s.ready)) begin
      word_full_reg <= 1'b0;
    end
  end

  // buffered word into the core receive register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_rx_full_reg <= 1'b0;
      core_rx_reg <= host_port_pkg::WORD_RESET;
    end else if (rx_s.valid && rx_s.ready) begin
      core_rx_full_reg <= 1'b1;
      core_rx_reg <= rx_s.data;
    end else if (i_core_rx_rd || boot_store) begin
      core_rx_full_reg <= 1'b0;
    end
  end

  // core-to-host path
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_tx_empty_reg <= 1'b1;
      core_tx_reg <= host_port_pkg::WORD_RESET;
    end else if (copy_out) begin
      core_tx_empty_reg <= 1'b1;
    end else if (i_core_tx_wr) begin
      core_tx_empty_reg <= 1'b0;
      core_tx_reg <= i_core_tx_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_rx_full_reg <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        rx_byte_reg[i] <= 8'h00;
      end
    end else if (copy_out) begin
      host_rx_full_reg <= 1'b1;
      rx_byte_reg[0] <= core_tx_reg[23:16];
      rx_byte_reg[1] <= core_tx_reg[15:8];
      rx_byte_reg[2] <= core_tx_reg[7:0];
    end else if (host_low_rd || (dma_rx && dma_low)) begin
      host_rx_full_reg <= 1'b0;
    end
  end

  // dma byte counter
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= host_port_pkg::IDX_LOW;
    end else if (i_init || !dma_on || dma_low) begin
      cnt_reg <= start_index(ws);
    end else if (dma_step) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // dma request pacing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      host_port_pkg::DMA_IDLE: begin
        if (i_host_ack_n && ((dma_tx && host_tx_empty) || (dma_rx && host_rx_full_reg))) begin
          state_next = host_port_pkg::DMA_REQ;
        end
      end
      host_port_pkg::DMA_REQ: begin
        if (ack_fall) begin
          state_next = host_port_pkg::DMA_ACK;
        end
      end
      host_port_pkg::DMA_ACK: begin
        if (ack_rise) begin
          state_next = host_port_pkg::DMA_IDLE;
        end
      end
      default: state_next = host_port_pkg::DMA_IDLE;
    endcase
    if (!dma_on || i_init) begin
      state_next = host_port_pkg::DMA_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= host_port_pkg::DMA_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    if (dma_on) begin
      o_host_request_n = (state_reg != host_port_pkg::DMA_REQ);
    end else begin
      o_host_request_n = ~((i_rx_request_enable & host_rx_full_reg) | (i_tx_request_enable & host_tx_empty));
    end
  end

  // host read data, registered
  always_comb begin
    rd_data_next = 8'h00;
    if (dma_rx && state_reg == host_port_pkg::DMA_ACK) begin
      rd_data_next = rx_byte_reg[cnt_reg];
    end else if (sel_byte) begin
      rd_data_next = rx_byte_reg[sel_idx];
    end else if (i_host_reg_select == host_port_pkg::ADDR_STATUS) begin
      rd_data_next = {6'h00, host_tx_empty, host_rx_full_reg};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign o_host_data_bus = rd_data_reg;
  assign o_host_data_oe = (~i_host_enable_n & i_host_rw) | (dma_rx & (state_reg == host_port_pkg::DMA_ACK));

  // core exceptions, level while receive full or transmit empty, receive vector first
  assign tx_irq = core_tx_empty_reg & i_core_tx_irq_enable & i_irq_unmasked;
  assign rx_irq = core_rx_full_reg & i_core_rx_irq_enable & i_irq_unmasked;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vector_reg <= host_port_pkg::VEC_NONE;
    end else if (rx_irq) begin
      vector_reg <= host_port_pkg::VEC_RX;
    end else if (tx_irq) begin
      vector_reg <= host_port_pkg::VEC_TX;
    end else begin
      vector_reg <= host_port_pkg::VEC_NONE;
    end
  end

  // bootstrap loader
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_host_reg <= 1'b0;
    end else if (i_boot_active) begin
      boot_host_reg <= ({i_boot_mode_bit_c, i_boot_mode_bit_b, i_boot_mode_bit_a} == host_port_pkg::BOOT_PATTERN);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_done_reg <= 1'b0;
      boot_wr_reg <= 1'b0;
      boot_addr_reg <= host_port_pkg::EXEC_START;
      boot_data_reg <= host_port_pkg::WORD_RESET;
      o_boot_addr <= host_port_pkg::EXEC_START;
    end else begin
      boot_wr_reg <= boot_store;
      if (boot_busy && i_host_flag_zero) begin
        boot_done_reg <= 1'b1;
      end else if (boot_store) begin
        boot_data_reg <= core_rx_reg;
        boot_addr_reg <= boot_addr_reg + 13'h0001;
        if (boot_addr_reg == BOOT_LAST) begin
          boot_done_reg <= 1'b1;
        end
      end
      if (boot_store) begin
        o_boot_addr <= boot_addr_reg;
      end
    end
  end

  assign o_core_rx_data = core_rx_reg;
  assign o_core_rx_full = core_rx_full_reg;
  assign o_core_tx_empty = core_tx_empty_reg;
  assign o_core_irq = rx_irq | tx_irq;
  assign o_core_irq_vector = vector_reg;
  assign o_boot_from_host = boot_host_reg;
  assign o_boot_wr = boot_wr_reg;
  assign o_boot_data = boot_data_reg;
  assign o_boot_done = boot_done_reg;
  assign o_exec_addr = host_port_pkg::EXEC_START;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_dma_ack_release;
    (state_reg == host_port_pkg::DMA_ACK) && ack_rise && (cnt_reg != host_port_pkg::IDX_LOW) &&
      dma_on && !i_init;
  endsequence

  sequence s_req_then_ack;
    (state_reg == host_port_pkg::DMA_REQ) ##1 ack_fall;
  endsequence

  a_boot_pattern_sel: assert property ($rose(boot_host_reg) |->
    $past({i_boot_mode_bit_c, i_boot_mode_bit_b, i_boot_mode_bit_a}) == 3'h5)
    else $error("boot source chosen without pattern 101");
  a_zero_reg_read: assert property (host_rd && i_host_reg_select == 3'h4 && !dma_rx |=>
    o_host_data_bus == 8'h00)
    else $error("byte 4 did not read zero");
  a_low_write_full: assert property (host_low_wr |=> !host_tx_empty)
    else $error("low byte write did not take the word");
  a_boot_early_stop: assert property (boot_busy && i_host_flag_zero |=> o_boot_done && !o_boot_wr)
    else $error("flag zero did not stop the loader");
  a_tx_wr_clears: assert property (i_core_tx_wr && o_core_tx_empty |=> !o_core_tx_empty)
    else $error("core write left transmit empty set");
  a_host_rd_clears: assert property (host_low_rd && host_rx_full_reg && o_core_tx_empty |=>
    !host_rx_full_reg)
    else $error("low byte read left receive full set");
  a_copy_word: assert property (!host_rx_full_reg && !o_core_tx_empty |=>
    host_rx_full_reg && o_core_tx_empty && {rx_byte_reg[0], rx_byte_reg[1], rx_byte_reg[2]} == $past(core_tx_reg))
    else $error("transmit word not copied");
  a_dma_req_only: assert property (dma_on && state_reg != host_port_pkg::DMA_REQ |-> o_host_request_n)
    else $error("request pin used outside dma request");
  a_ack_drops_req: assert property (s_req_then_ack |=> o_host_request_n)
    else $error("request still high after ack");
  a_dma_step: assert property (s_dma_ack_release |=>
    cnt_reg == $past(cnt_reg) + 2'h1 ##1 (!o_host_request_n || !dma_tx || !host_tx_empty))
    else $error("dma counter did not step or request not renewed");
endmodule
`default_nettype wire

// >>> test/host_agent.sv
// host processor and external dma controller model on the host port pins
// assumes the port samples its pins on the rising edge; this model moves them on the falling edge
`default_nettype none
module host_agent (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_data,
  input wire logic i_request_n,
  output logic o_enable_n,
  output logic o_rw,
  output logic [2:0] o_sel,
  output logic [7:0] o_data,
  output logic o_ack_n,
  input wire logic i_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  bit timed_out;
  initial begin
    o_enable_n = 1'b1;
    o_rw = 1'b1;
    o_sel = 3'h0;
    o_data = 8'h5a;
    o_ack_n = 1'b1;
  end
  // one strobe over two edges; a released bus shows the inverse byte
  task automatic access(input logic rw, input logic [2:0] sel, input logic [7:0] d, output logic [7:0] q,
    output logic oe);
    @(negedge i_ref_clk);
    o_rw = rw;
    o_sel = sel;
    o_data = d;
    o_enable_n = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    q = i_data;
    oe = i_oe;
    o_enable_n = 1'b1;
    o_data = ~d;
  endtask
  task automatic wait_req();
    int n;
    for (n = 0; n < 200 && i_request_n !== 1'b0; n++) @(negedge i_ref_clk);
    if (n == 200) timed_out = 1'b1;
  endtask
  // one dma byte: ack held past the request drop, then released to latch the byte
  task automatic dma(input logic [7:0] d, output logic [7:0] q, output logic req_n);
    wait_req();
    o_data = d;
    o_ack_n = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    req_n = i_request_n;
    q = i_data;
    o_ack_n = 1'b1;
    @(negedge i_ref_clk);
    o_data = ~d;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench of the host port: host words, core words, dma both ways, boot load
// assumes host_agent drives the host pins; core side and controls driven here on falling edges
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk, i_rst_n, i_boot_active, i_boot_mode_bit_c, i_boot_mode_bit_b, i_boot_mode_bit_a;
  logic i_host_enable_n, i_host_rw, i_host_ack_n, i_init, i_host_flag_zero, i_rx_request_enable;
  logic i_tx_request_enable, i_word_size_bit1, i_word_size_bit0, i_core_tx_wr, i_core_rx_rd;
  logic i_core_tx_irq_enable, i_core_rx_irq_enable, i_irq_unmasked, o_host_request_n, o_core_rx_full;
  logic o_core_tx_empty, o_core_irq, o_boot_from_host, o_boot_wr, o_boot_done, full_q, host_oe;
  logic [2:0] i_host_reg_select;
  logic [7:0] i_host_data_bus, o_host_data_bus, o_core_irq_vector;
  logic [12:0] o_boot_addr, o_exec_addr, boot_a;
  logic [23:0] i_core_tx_data, o_core_rx_data, o_boot_data, boot_d;
  int n_errors, total_checks, words, boot_n;
  host_port #(.BOOT_WORDS(4)) i_host_port (.i_ref_clk, .i_rst_n, .i_boot_active, .i_boot_mode_bit_c,
    .i_boot_mode_bit_b, .i_boot_mode_bit_a, .i_host_enable_n, .i_host_rw, .i_host_reg_select,
    .i_host_data_bus, .o_host_data_bus, .o_host_data_oe(host_oe), .i_host_ack_n, .o_host_request_n, .i_init,
    .i_host_flag_zero, .i_rx_request_enable, .i_tx_request_enable, .i_word_size_bit1, .i_word_size_bit0,
    .i_core_tx_wr, .i_core_tx_data, .i_core_rx_rd, .o_core_rx_data, .o_core_rx_full, .o_core_tx_empty,
    .i_core_tx_irq_enable, .i_core_rx_irq_enable, .i_irq_unmasked, .o_core_irq, .o_core_irq_vector,
    .o_boot_from_host, .o_boot_wr, .o_boot_addr, .o_boot_data, .o_boot_done, .o_exec_addr);
  host_agent i_host_agent (.i_ref_clk, .i_data(o_host_data_bus), .i_request_n(o_host_request_n),
    .o_enable_n(i_host_enable_n), .o_rw(i_host_rw), .o_sel(i_host_reg_select), .o_data(i_host_data_bus),
    .o_ack_n(i_host_ack_n), .i_oe(host_oe));
  // counts words arriving at the core and records boot memory writes
  always @(posedge i_ref_clk) begin
    full_q <= o_core_rx_full;
    if (o_core_rx_full === 1'b1 && full_q === 1'b0) words <= words + 1;
    if (o_boot_wr === 1'b1) begin
      boot_n <= boot_n + 1;
      boot_a <= o_boot_addr;
      boot_d <= o_boot_data;
    end
  end
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic guard(input logic t);
    if (t || i_host_agent.timed_out) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    logic [7:0] q;
    logic oe;
    i_host_agent.access(1'b0, s, d, q, oe);
    check("write drive", 24'(oe), 24'h0);
  endtask
  task automatic rd_chk(input string what, input logic [2:0] s, input logic [7:0] exp);
    logic [7:0] q;
    logic oe;
    i_host_agent.access(1'b1, s, 8'h00, q, oe);
    check(what, 24'(q), 24'(exp));
    check("read drive", 24'(oe), 24'h1);
  endtask
  task automatic dma(input logic [7:0] d, output logic [7:0] q);
    logic req_n;
    i_host_agent.dma(d, q, req_n);
    guard(1'b0);
    check("request under ack", 24'(req_n), 24'h1);
  endtask
  task automatic mode(input logic [1:0] ws, input logic tx, input logic rx);
    i_init = 1'b1;
    {i_word_size_bit1, i_word_size_bit0} = ws;
    i_tx_request_enable = tx;
    i_rx_request_enable = rx;
    @(negedge i_ref_clk);
    i_init = 1'b0;
  endtask
  task automatic core_wr(input logic [23:0] d);
    i_core_tx_data = d;
    i_core_tx_wr = 1'b1;
    @(negedge i_ref_clk);
    i_core_tx_wr = 1'b0;
  endtask
  task automatic core_take(input logic [23:0] exp, input logic [23:0] mask);
    int n;
    for (n = 0; n < 100 && o_core_rx_full !== 1'b1; n++) @(negedge i_ref_clk);
    guard(n == 100);
    check("core word", o_core_rx_data & mask, exp & mask);
    i_core_rx_rd = 1'b1;
    @(negedge i_ref_clk);
    i_core_rx_rd = 1'b0;
    @(negedge i_ref_clk);
  endtask
  task automatic t_host_word();
    i_core_rx_irq_enable = 1'b1;
    i_irq_unmasked = 1'b1;
    rd_chk("zero byte", 3'h4, 8'h00);
    wr(3'h4, 8'hee);
    wr(3'h5, 8'h12);
    wr(3'h6, 8'h34);
    check("early push", 24'(o_core_rx_full), 24'h0);
    wr(3'h7, 8'h56);
    wr(3'h5, 8'hab);
    wr(3'h6, 8'hcd);
    wr(3'h7, 8'hef);
    check("rx irq", 24'(o_core_irq), 24'h1);
    check("rx vector", 24'(o_core_irq_vector), 24'h20);
    core_take(24'h123456, 24'hffffff);
    core_take(24'habcdef, 24'hffffff);
    repeat (2) @(negedge i_ref_clk);
    check("rx cleared", 24'(o_core_rx_full), 24'h0);
    i_core_rx_irq_enable = 1'b0;
  endtask
  task automatic t_core_word();
    i_rx_request_enable = 1'b1;
    i_core_tx_irq_enable = 1'b1;
    @(negedge i_ref_clk);
    check("idle request", 24'(o_host_request_n), 24'h1);
    check("tx irq", 24'(o_core_irq), 24'h1);
    check("tx vector", 24'(o_core_irq_vector), 24'h22);
    core_wr(24'h123456);
    i_host_agent.wait_req();
    guard(1'b0);
    core_wr(24'h789abc);
    repeat (3) @(negedge i_ref_clk);
    check("tx held", 24'(o_core_tx_empty), 24'h0);
    check("tx irq off", 24'(o_core_irq), 24'h0);
    rd_chk("status full", 3'h0, 8'h03);
    rd_chk("rx high", 3'h5, 8'h12);
    rd_chk("rx mid", 3'h6, 8'h34);
    rd_chk("rx low", 3'h7, 8'h56);
    repeat (3) @(negedge i_ref_clk);
    check("tx refill", 24'(o_core_tx_empty), 24'h1);
    rd_chk("rx low again", 3'h7, 8'hbc);
    rd_chk("status empty", 3'h0, 8'h02);
    check("request off", 24'(o_host_request_n), 24'h1);
    i_core_tx_irq_enable = 1'b0;
  endtask
  task automatic t_dma_tx();
    logic [7:0] q, b;
    logic [23:0] exp [4];
    int w0;
    for (int ws = 1; ws < 4; ws++) begin
      mode(2'(ws), 1'b1, 1'b0);
      w0 = words;
      for (int k = 0; k < 4; k++) begin
        exp[k] = 24'h0;
        for (int j = 0; j < 4 - ws; j++) begin
          b = 8'(64 * ws + 16 * k + j + 1);
          dma(b, q);
          exp[k] = {exp[k][15:0], b};
        end
      end
      repeat (4) @(negedge i_ref_clk);
      check("stall request", 24'(o_host_request_n), 24'h1);
      for (int k = 0; k < 4; k++) core_take(exp[k], 24'hffffff >> (8 * (ws - 1)));
      check("word count", 24'(words - w0), 24'h4);
    end
    mode(2'h0, 1'b0, 1'b0);
  endtask
  task automatic t_dma_rx();
    logic [7:0] q;
    mode(2'h1, 1'b0, 1'b1);
    core_wr(24'ha1b2c3);
    for (int j = 0; j < 3; j++) begin
      dma(8'h00, q);
      check("dma read", 24'(q), 24'(8'ha1 + 8'(17 * j)));
    end
    @(negedge i_ref_clk);
    check("request after word", 24'(o_host_request_n), 24'h1);
    rd_chk("status in dma", 3'h0, 8'h02);
    mode(2'h0, 1'b0, 1'b0);
  endtask
  task automatic boot_word(input int k);
    int n, n0;
    n0 = boot_n;
    wr(3'h4, 8'h00);
    wr(3'h5, 8'(k + 1));
    wr(3'h6, 8'h22);
    wr(3'h7, 8'h33);
    for (n = 0; n < 100 && boot_n == n0; n++) @(negedge i_ref_clk);
    guard(n == 100);
    check("boot addr", 24'(boot_a), 24'(k));
    check("boot word", boot_d, {8'(k + 1), 16'h2233});
  endtask
  task automatic t_boot();
    i_boot_active = 1'b1;
    i_boot_mode_bit_c = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    check("other source", 24'(o_boot_from_host), 24'h0);
    i_boot_mode_bit_a = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    check("host boot", 24'(o_boot_from_host), 24'h1);
    for (int k = 0; k < 2; k++) boot_word(k);
    check("boot busy", 24'(o_boot_done), 24'h0);
    i_host_flag_zero = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    check("boot stop", 24'(o_boot_done), 24'h1);
    check("start addr", 24'(o_exec_addr), 24'h0);
    // reset in mid run, then a full load that ends at the word limit
    i_rst_n = 1'b0;
    i_host_flag_zero = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    @(negedge i_ref_clk);
    for (int k = 0; k < 4; k++) boot_word(k);
    repeat (2) @(negedge i_ref_clk);
    check("boot limit", 24'(o_boot_done), 24'h1);
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_rst_n = 1'b0;
    {i_boot_active, i_boot_mode_bit_c, i_boot_mode_bit_b, i_boot_mode_bit_a, i_init, i_host_flag_zero} = '0;
    {i_rx_request_enable, i_tx_request_enable, i_word_size_bit1, i_word_size_bit0, i_core_tx_wr} = '0;
    {i_core_rx_rd, i_core_tx_irq_enable, i_core_rx_irq_enable, i_irq_unmasked, i_core_tx_data} = '0;
    repeat (10) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    @(negedge i_ref_clk);
    check("tx empty", 24'(o_core_tx_empty), 24'h1);
    check("rx full", 24'(o_core_rx_full), 24'h0);
    rd_chk("status", 3'h0, 8'h02);
    t_host_word();
    t_core_word();
    t_dma_tx();
    t_dma_rx();
    t_boot();
    close_out();
  end
endmodule
`default_nettype wire
